// *** core/gop_packer.sv ***
// Purpose: frames the measured offsets report into a byte stream
// Assumes: request and report come from logic on clk_i
// Notes:   one report in flight; the snapshot is taken on request
`timescale 1ns/1ps
`include "gop_defines.svh"
module gop_packer
  import gop_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           send_i,
  input  wire gop_report_type report_i,
  output logic                busy_o,
  output logic                done_o,
  output logic                tx_valid_o,
  input  wire logic           tx_ready_i,
  output logic      [7:0]     tx_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // sanitising

  // flag bit that guards each offset slot
  function automatic logic [4:0] slot_bit(input logic [3:0] k);
    case (k)
      4'd0:    slot_bit = 5'd0;
      4'd1:    slot_bit = 5'd2;
      4'd2:    slot_bit = 5'd4;
      4'd3:    slot_bit = 5'd12;
      4'd4:    slot_bit = 5'd14;
      4'd5:    slot_bit = 5'd16;
      4'd6:    slot_bit = 5'd17;
      4'd7:    slot_bit = 5'd21;
      4'd8:    slot_bit = 5'd23;
      default: slot_bit = 5'd26;
    endcase
  endfunction

  gop_report_type clean;

  always_comb
  begin
    clean       = report_i;
    clean.flags = report_i.flags & `GOP_FLAG_MASK;
    // out-of-range time is clamped rather than dropped, so the report still goes
    if (report_i.time_of_week_seconds > `GOP_TOW_MAX)
      clean.time_of_week_seconds = `GOP_TOW_MAX;
    for (int k = 0; k < 10; k++)
    begin
      if (!clean.flags[slot_bit(4'(k))])
        clean.offset[k] = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  gop_state_type  state;
  gop_report_type snap;
  logic [5:0]     pos;
  logic [7:0]     csum;
  logic [7:0]     body_byte;
  logic [7:0]     next_byte;
  logic           push;
  logic           fifo_ready;
  logic           fifo_valid;
  logic [7:0]     fifo_data;
  logic           drain;

  gop_byte_sel u_sel (
    .report_i (snap),
    .pos_i    (pos),
    .byte_o   (body_byte)
  );

  always_comb
  begin
    if (pos == `GOP_POS_CSUM)
      next_byte = csum;
    else if (pos == `GOP_POS_DELIM)
      next_byte = `GOP_DELIM;
    else if (pos == `GOP_POS_LAST)
      next_byte = `GOP_END;
    else
      next_byte = body_byte;
  end

  assign push = (state == GOP_EMIT) && fifo_ready;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= GOP_IDLE;
      pos   <= 6'd0;
    end
    else
    begin
      case (state)
        GOP_IDLE:
        begin
          pos <= 6'd0;
          if (send_i)
            state <= GOP_EMIT;
        end
        GOP_EMIT:
        begin
          if (push)
          begin
            if (pos == `GOP_POS_LAST)
            begin
              state <= GOP_IDLE;
              pos   <= 6'd0;
            end
            else
            begin
              pos <= pos + 6'd1;
            end
          end
        end
        default:
        begin
          state <= GOP_IDLE;
        end
      endcase
    end
  end

  // snapshot holds steady while the packet is being framed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      snap <= '0;
    else if (state == GOP_IDLE && send_i)
      snap <= clean;
  end

  // xor of packet id up to the last data byte
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      csum <= 8'h00;
    else if (state == GOP_IDLE)
      csum <= 8'h00;
    else if (push && pos >= `GOP_POS_PID && pos < `GOP_POS_CSUM)
      csum <= csum ^ next_byte;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      busy_o <= (state == GOP_IDLE) ? send_i : !(push && pos == `GOP_POS_LAST);
      done_o <= push && pos == `GOP_POS_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffering and output register

  gop_fifo #(
    .WIDTH (8),
    .DEPTH (`GOP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (next_byte),
    .out_valid_o (fifo_valid),
    .out_ready_i (drain),
    .out_data_o  (fifo_data)
  );

  // a stalled host fills the buffer and then holds the framer
  assign drain = !tx_valid_o || tx_ready_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end
    else if (drain)
    begin
      tx_valid_o <= fifo_valid;
      tx_data_o  <= fifo_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  localparam logic [15:0] LEN_WORD = `GOP_LEN;

  flags_reserved_a: assert property (state == GOP_EMIT
                                     |-> (snap.flags & ~`GOP_FLAG_MASK) == 32'h0)
    else $error("reserved flag bit set in report");

  flag_kept_a: assert property (state == GOP_IDLE && send_i && report_i.flags[26]
                                |=> snap.flags[26])
    else $error("navic flag lost in snapshot");

  tow_range_a: assert property (push && pos == `GOP_POS_TOW
                                |-> snap.time_of_week_seconds <= `GOP_TOW_MAX)
    else $error("time of week out of range");

  zero_offset_a: assert property (state == GOP_EMIT && !snap.flags[14]
                                  |-> snap.offset[4] == 32'h0)
    else $error("untracked offset not zero");

  header_ids_a: assert property (push && pos == `GOP_POS_PID
                                 |-> next_byte == `GOP_PACKET_ID
                                 ##[1:300] push && pos == `GOP_POS_SID
                                 && next_byte == `GOP_SUB_ID)
    else $error("packet ids wrong");

  length_hi_a: assert property (push && pos == `GOP_POS_LEN_HI
                                |-> next_byte == LEN_WORD[15:8])
    else $error("length byte wrong");

  length_lo_a: assert property (push && pos == `GOP_POS_LEN_LO
                                |-> next_byte == LEN_WORD[7:0])
    else $error("length low byte wrong");

  mode_byte_a: assert property (push && pos == `GOP_POS_MODE
                                |-> next_byte == `GOP_MODE_RESP)
    else $error("mode byte wrong");

  flags_msb_a: assert property (push && pos == `GOP_POS_FLAGS
                                |-> next_byte == snap.flags[31:24])
    else $error("flag word byte order wrong");

  flags_lsb_a: assert property (push && pos == 6'd9 |-> next_byte == snap.flags[7:0])
    else $error("flag word low byte wrong");

  week_msb_a: assert property (push && pos == `GOP_POS_WEEK |-> next_byte == snap.week[15:8])
    else $error("week byte order wrong");

  week_lsb_a: assert property (push && pos == 6'd11 |-> next_byte == snap.week[7:0])
    else $error("week low byte wrong");

  tow_msb_a: assert property (push && pos == `GOP_POS_TOW
                              |-> next_byte == snap.time_of_week_seconds[31:24])
    else $error("time of week high byte wrong");

  tow_lsb_a: assert property (push && pos == 6'd15
                              |-> next_byte == snap.time_of_week_seconds[7:0])
    else $error("time of week low byte wrong");

  gps_offset_a: assert property (push && pos == 6'd19 |-> next_byte == snap.offset[0][7:0])
    else $error("gps l1 offset byte wrong");

  gps_l5_a: assert property (push && pos == 6'd20
                             |-> next_byte == snap.offset[1][31:24])
    else $error("gps l5 offset byte wrong");

  glonass_byte_a: assert property (push && pos == 6'd25
                                   |-> next_byte == snap.offset[2][23:16])
    else $error("glonass offset byte wrong");

  b1_byte_a: assert property (push && pos == 6'd30
                              |-> next_byte == snap.offset[3][15:8])
    else $error("beidou b1 offset byte wrong");

  b2a_byte_a: assert property (push && pos == 6'd35
                               |-> next_byte == snap.offset[4][7:0])
    else $error("beidou b2a offset byte wrong");

  e1_byte_a: assert property (push && pos == 6'd36
                              |-> next_byte == snap.offset[5][31:24])
    else $error("galileo e1 offset byte wrong");

  e5a_byte_a: assert property (push && pos == 6'd41
                               |-> next_byte == snap.offset[6][23:16])
    else $error("galileo e5a offset byte wrong");

  qzss_l1_a: assert property (push && pos == 6'd46
                              |-> next_byte == snap.offset[7][15:8])
    else $error("qzss l1 offset byte wrong");

  qzss_l5_a: assert property (push && pos == 6'd51
                              |-> next_byte == snap.offset[8][7:0])
    else $error("qzss l5 offset byte wrong");

  navic_offset_a: assert property (push && pos == 6'd52
                                   |-> next_byte == snap.offset[9][31:24])
    else $error("navic offset byte wrong");

  navic_zero_a: assert property (state == GOP_EMIT && !snap.flags[26]
                                 |-> snap.offset[9] == 32'h0)
    else $error("untracked navic offset not zero");

  tracked_kept_a: assert property (state == GOP_IDLE && send_i && report_i.flags[0]
                                   |=> snap.offset[0] == $past(report_i.offset[0]))
    else $error("tracked offset lost in snapshot");

  tail_bytes_a: assert property (push && pos == `GOP_POS_DELIM
                                 |-> next_byte == `GOP_DELIM
                                 ##[1:300] push && pos == `GOP_POS_LAST && next_byte == `GOP_END)
    else $error("end delimiter wrong");

  done_pulse_a: assert property (push && pos == `GOP_POS_LAST |=> done_o ##1 !done_o)
    else $error("done pulse wrong");

  busy_take_a: assert property (state == GOP_IDLE && send_i |=> busy_o)
    else $error("busy not raised on request");

  snap_frozen_a: assert property (state == GOP_EMIT |=> $stable(snap))
    else $error("snapshot changed during frame");

  fifo_order_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("output changed while stalled");

  report_sent_c: cover property (push && pos == `GOP_POS_LAST);
  host_stall_c:  cover property (state == GOP_EMIT && !fifo_ready);
  back_to_back_c: cover property (done_o && send_i);
  host_slow_c:   cover property (tx_valid_o && !tx_ready_i);
  tow_clamp_c:   cover property (state == GOP_IDLE && send_i
                                 && report_i.time_of_week_seconds > `GOP_TOW_MAX);

endmodule

// *** core/gop_defines.svh ***
// Purpose: constants for the offset report packer
// Assumes: one clock, bytes leave most significant first
// Notes:   positions are byte indices within one report packet
//
// Functional notes
// - valid flags: 14 B2a, 16 E1, 17 E5a, 21 QZSS L1C, 23 QZSS L5, 26 NavIC.
// - reserved flag bits 13,15,18,20,22,24,25,27,28-31 are never set.
// - bytes 10-11 carry the unsigned 16-bit week number of the computation.
// - bytes 12-15 carry time of week, always within 0 to 604799.
// - bytes 16-19: GPS L1 offset float, nanoseconds.
// - bytes 20-23: GPS L5 offset float, nanoseconds.
// - bytes 24-27: GLONASS offset float, nanoseconds.
// - bytes 28-31: Beidou B1 offset float, nanoseconds.
// - bytes 32-35: Beidou B2a offset float, nanoseconds.
// - bytes 36-39: Galileo E1 offset float, nanoseconds.
// - bytes 40-43: Galileo E5a offset float, nanoseconds.
// - bytes 44-47: QZSS L1 offset float, nanoseconds.
// - bytes 48-51: QZSS L5 offset float, nanoseconds.
// - bytes 52-55: NavIC L5 offset float, nanoseconds.
// - an offset is meaningful only while its flag bit is set.
// - length field counts mode, data and checksum bytes together.
// - report answers query with packet id 0xa1, subpacket 0x22.
`ifndef GOP_DEFINES_SVH
`define GOP_DEFINES_SVH

`define GOP_DELIM       8'h10
`define GOP_END         8'h03
`define GOP_PACKET_ID   8'ha1
`define GOP_SUB_ID      8'h22
`define GOP_LEN         16'h0034
`define GOP_MODE_RESP   8'h02
`define GOP_FLAG_MASK   32'h04a3_5015
`define GOP_TOW_MAX     32'd604799
`define GOP_POS_START   6'd0
`define GOP_POS_PID     6'd1
`define GOP_POS_SID     6'd2
`define GOP_POS_LEN_HI  6'd3
`define GOP_POS_LEN_LO  6'd4
`define GOP_POS_MODE    6'd5
`define GOP_POS_FLAGS   6'd6
`define GOP_POS_WEEK    6'd10
`define GOP_POS_TOW     6'd12
`define GOP_POS_OFFSET  6'd16
`define GOP_POS_CSUM    6'd56
`define GOP_POS_DELIM   6'd57
`define GOP_POS_LAST    6'd58
`define GOP_FIFO_DEPTH  8

`endif

// *** core/gop_pkg.sv ***
// Purpose: types for the offset report packer
// Assumes: offsets are raw IEEE single words
// Notes:   offset[0] is GPS L1 through offset[9] NavIC L5
package gop_pkg;

  typedef struct packed {
    logic [31:0]      flags;
    logic [15:0]      week;
    logic [31:0]      time_of_week_seconds;
    logic [9:0][31:0] offset;
  } gop_report_type;

  typedef enum logic [1:0] {
    GOP_IDLE = 2'b00,
    GOP_EMIT = 2'b01
  } gop_state_type;

endpackage

// *** core/gop_fifo.sv ***
// Purpose: byte buffer between packer and serial output stage
// Assumes: single clock, depth a power of two
// Notes:   full and empty come from a pointer pair with a wrap bit
`timescale 1ns/1ps
module gop_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (in_valid_i && !full)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid_i && !full)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready_i && !empty)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

// *** core/gop_byte_sel.sv ***
// Purpose: picks the payload byte for one packet position
// Assumes: report already sanitised by the caller
// Notes:   positions 56 and up are handled by the caller
`timescale 1ns/1ps
`include "gop_defines.svh"
module gop_byte_sel
  import gop_pkg::*;
(
  input  wire gop_report_type report_i,
  input  wire logic [5:0]     pos_i,
  output logic      [7:0]     byte_o
);

  // big-endian byte k of a word
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] k);
    word_byte = w[(5'd24 - {k, 3'b000}) +: 8];
  endfunction

  // a literal cannot be part-selected, so the length word is named first
  localparam logic [15:0] LEN_WORD = `GOP_LEN;

  logic [5:0] rel;
  logic [3:0] slot;

  always_comb
  begin
    rel    = pos_i - `GOP_POS_OFFSET;
    slot   = rel[5:2];
    byte_o = 8'h00;
    if (pos_i == `GOP_POS_START)
      byte_o = `GOP_DELIM;
    else if (pos_i == `GOP_POS_PID)
      byte_o = `GOP_PACKET_ID;
    else if (pos_i == `GOP_POS_SID)
      byte_o = `GOP_SUB_ID;
    else if (pos_i == `GOP_POS_LEN_HI)
      byte_o = LEN_WORD[15:8];
    else if (pos_i == `GOP_POS_LEN_LO)
      byte_o = LEN_WORD[7:0];
    else if (pos_i == `GOP_POS_MODE)
      byte_o = `GOP_MODE_RESP;
    else if (pos_i < `GOP_POS_WEEK)
      byte_o = word_byte(report_i.flags, 2'(pos_i - `GOP_POS_FLAGS));
    else if (pos_i < `GOP_POS_TOW)
      byte_o = word_byte({report_i.week, 16'h0000}, 2'(pos_i - `GOP_POS_WEEK));
    else if (pos_i < `GOP_POS_OFFSET)
      byte_o = word_byte(report_i.time_of_week_seconds, 2'(pos_i - `GOP_POS_TOW));
    else if (pos_i < `GOP_POS_CSUM && slot < 4'd10)
      // offsets in slot order, 4 bytes each
      byte_o = word_byte(report_i.offset[slot], rel[1:0]);
  end

endmodule

// *** testbench/gop_host_model.sv ***
// Purpose: host reader of the offset report byte stream
// Assumes: bytes are taken on clk_i where valid and ready are both high
// Notes:   slow pacing holds ready low long enough to fill the buffer
`timescale 1ns/1ps
module gop_host_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] rx_byte [0:255];
  logic [7:0] rx_count = 8'h00;
  logic [4:0] pace     = 5'h00;
  ////////////////////////////////////////////////////////////////////////////
  // ready moves only at the falling edge, away from the sampling edge
  always @(negedge clk_i)
  begin
    pace <= pace + 5'h01;
    tx_ready_o <= !slow_i || (pace > 5'h18);
  end
  // no reset here: a frame cut by reset leaves its bytes, the bench rebases
  always @(posedge clk_i)
  begin
    if (tx_valid_i && tx_ready_o)
    begin
      rx_byte[rx_count] <= tx_data_i;
      rx_count <= rx_count + 8'h01;
    end
  end
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench of the offset report packer
// Assumes: inputs change at the falling edge of clk_i
// Notes:   expected bytes are rebuilt here from the field layout
`timescale 1ns/1ps
module tb;
  import gop_pkg::*;
  logic           clk_i  = 1'b0;
  logic           rst_i  = 1'b1;
  logic           send_i = 1'b0;
  logic           slow   = 1'b0;
  logic           tx_ready;
  logic           busy;
  logic           done;
  logic           tx_valid;
  logic [7:0]     tx_data;
  gop_report_type report = '0;
  logic [7:0]     exp_b [0:58];
  int             miscompares = 0;
  int             compares    = 0;
  int             cycles      = 0;
  int             flag_pos [10] = '{0, 2, 4, 12, 14, 16, 17, 21, 23, 26};
  always #12.5 clk_i = !clk_i;
  gop_packer i_gop_packer (.clk_i(clk_i), .rst_i(rst_i), .send_i(send_i), .report_i(report),
    .busy_o(busy), .done_o(done), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .tx_data_o(tx_data));
  gop_host_model i_gop_host_model (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] expv, input logic [7:0] got);
    compares++;
    if (got !== expv)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expv, got);
    end
  endtask
  // tow beyond a week is clamped, untracked offsets go out as zero
  task automatic expect_pkt(input gop_report_type r);
    logic [31:0] f;
    logic [31:0] t;
    logic [7:0]  x;
    f = r.flags & 32'h04a3_5015;
    t = (r.time_of_week_seconds > 32'd604799) ? 32'd604799 : r.time_of_week_seconds;
    exp_b[0] = 8'h10;
    exp_b[1] = 8'ha1;
    exp_b[2] = 8'h22;
    exp_b[3] = 8'h00;
    exp_b[4] = 8'h34;
    exp_b[5] = 8'h02;
    exp_b[10] = r.week[15:8];
    exp_b[11] = r.week[7:0];
    for (int k = 0; k < 4; k++)
    begin
      exp_b[6 + k] = f[31 - 8 * k -: 8];
      exp_b[12 + k] = t[31 - 8 * k -: 8];
      for (int i = 0; i < 10; i++)
        exp_b[16 + 4 * i + k] = f[flag_pos[i]] ? r.offset[i][31 - 8 * k -: 8] : 8'h00;
    end
    x = 8'h00;
    for (int k = 1; k <= 55; k++)
      x = x ^ exp_b[k];
    exp_b[56] = x;
    exp_b[57] = 8'h10;
    exp_b[58] = 8'h03;
  endtask
  task automatic cmp(input logic [7:0] base, input int lo, input int hi);
    for (int k = lo; k <= hi; k++)
      chk("packet byte", exp_b[k], i_gop_host_model.rx_byte[base + 8'(k)]);
  endtask
  function automatic gop_report_type mk(input logic [31:0] f, input logic [31:0] t);
    gop_report_type r;
    r.flags = f;
    r.week = 16'h10a5;
    r.time_of_week_seconds = t;
    for (int i = 0; i < 10; i++)
      r.offset[i] = {8'h10, 8'(i), 8'hc1, 8'(i * 37)};
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    repeat (20) @(negedge clk_i);
    chk("busy in reset", 8'h00, {7'h00, busy});
    chk("valid in reset", 8'h00, {7'h00, tx_valid});
    chk("done in reset", 8'h00, {7'h00, done});
    chk("data in reset", 8'h00, tx_data);
    rst_i = 1'b0;
  endtask
  // poke sends a request mid-frame, which must be ignored
  task automatic frame(input gop_report_type r, input logic s, input logic poke);
    logic [7:0] base;
    int         n;
    expect_pkt(r);
    base = i_gop_host_model.rx_count;
    slow = s;
    report = r;
    send_i = 1'b1;
    @(negedge clk_i);
    send_i = 1'b0;
    report = '0;
    chk("busy", 8'h01, {7'h00, busy});
    if (poke)
    begin
      repeat (5) @(negedge clk_i);
      send_i = 1'b1;
      @(negedge clk_i);
      send_i = 1'b0;
    end
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    n = 0;
    while (8'(i_gop_host_model.rx_count - base) != 8'd59 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    repeat (20) @(negedge clk_i);
    chk("byte count", 8'd59, i_gop_host_model.rx_count - base);
    chk("busy after frame", 8'h00, {7'h00, busy});
    cmp(base, 0, 5);
    cmp(base, 6, 9);
    cmp(base, 10, 11);
    cmp(base, 12, 15);
    cmp(base, 16, 19);
    cmp(base, 20, 23);
    cmp(base, 24, 27);
    cmp(base, 28, 31);
    cmp(base, 32, 35);
    cmp(base, 36, 39);
    cmp(base, 40, 43);
    cmp(base, 44, 47);
    cmp(base, 48, 51);
    cmp(base, 52, 55);
    cmp(base, 56, 58);
  endtask
  task automatic s_mid_reset;
    report = mk(32'hffff_ffff, 32'd12);
    send_i = 1'b1;
    @(negedge clk_i);
    send_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    chk("busy in reset", 8'h00, {7'h00, busy});
    chk("valid in reset", 8'h00, {7'h00, tx_valid});
    rst_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    s_reset();
    frame(mk(32'hffff_ffff, 32'd700000), 1'b0, 1'b0);
    frame(mk(32'hf84a_a014, 32'd604799), 1'b1, 1'b1);
    s_mid_reset();
    frame(mk(32'h0000_0000, 32'd0), 1'b0, 1'b0);
    summarize();
  end
endmodule
